//--- hw/adcr_pkg.sv
// Package with register map, field layout and carrier types for the conductance bank
package adcr_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // Byte addresses of the registers
  localparam logic [7:0] N_ON_IDX   = 8'h27;
  localparam logic [7:0] P_CW_IDX   = 8'h28;
  localparam logic [7:0] P_MOD_IDX  = 8'h29;
  localparam logic [7:0] N_OFF_IDX  = 8'h2a;
  localparam logic [7:0] CTRL_IDX   = 8'h2b;
  localparam logic [7:0] STAT_IDX   = 8'h2c;

  // Reset values
  localparam logic [7:0] N_ON_RST   = 8'h88;
  localparam logic [7:0] P_CW_RST   = 8'h20;
  localparam logic [7:0] P_MOD_RST  = 8'h20;
  localparam logic [7:0] N_OFF_RST  = 8'h88;
  localparam logic [7:0] CTRL_RST   = 8'h00;

  // Field positions
  localparam int unsigned N_CW_LSB  = 4;
  localparam int unsigned N_W       = 4;
  localparam int unsigned P_W       = 6;
  localparam logic [7:0] P_MASK     = 8'h3f;
  localparam int unsigned CTRL_PD   = 0;
  localparam int unsigned CTRL_ASK  = 1;
  localparam int unsigned CTRL_TX1  = 2;
  localparam int unsigned CTRL_TX2  = 3;
  localparam int unsigned CTRL_MOD  = 4;
  localparam logic [7:0] CTRL_MASK  = 8'h1f;

  typedef struct packed {
    logic [3:0] n_cond;
    logic [5:0] p_cond;
    logic       full_ask;
  } adcr_drive_type;

endpackage

//--- hw/adcr_weight.sv
// Binary weighted expansion of one conductance field with power-down forcing
`timescale 1ns/10ps
module adcr_weight #(
  parameter int unsigned W = 4
) (
  input  wire logic [W-1:0]      field,
  input  wire logic              power_down,
  output logic [(1<<W)-2:0]      segments
);
  logic [W-1:0] eff;

  assign eff = power_down ? (field | {1'b1, {(W-1){1'b0}}}) : field; // [R5]

  // Bit k enables 2**k unit segments
  genvar k;
  generate
    for (k = 0; k < W; k++) begin : g_bit
      assign segments[(1<<(k+1))-2 -: (1<<k)] = {(1<<k){eff[k]}}; // [R4]
    end
  endgenerate
endmodule // adcr_weight

//--- hw/adcr_regs.sv
// Antenna driver conductance register bank with Avalon-MM slave
//
// Behaviour
// (R1) N-on register 27h, fields 7..4/3..0, reset 88h
// (R2) Modulation uses modulation field, else carrier field
// (R3) N-on values only while a driver on
// (R4) Fields are binary weighted conductance
// (R5) Soft power-down forces each field MSB high; P stays zero while modulating with full ASK
// (R6) P carrier register 28h, bits 5..0, reset 20h
// (R7) P modulation register 29h, bits 5..0, reset 20h
// (R8) Forced full ASK voids P modulation value
// (R9) P register bits 7..6 read zero
// (R10) N-off register gives values when drivers off
// (R11) Writes to reserved P bits ignored
//
// Our own choice: the Avalon-MM interface to the registers.
`timescale 1ns/10ps
module adcr_regs (
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  output logic [1:0]       avs_response,
  input  wire logic        modulation_in,
  output logic [3:0]       n_conductance,
  output logic [5:0]       p_conductance,
  output logic             forced_full_ask,
  output logic [14:0]      n_segments,
  output logic [62:0]      p_segments
);
  logic [7:0] n_on_q;
  logic [7:0] p_cw_q;
  logic [7:0] p_mod_q;
  logic [7:0] n_off_q;
  logic [7:0] ctrl_q;
  logic       mod_s1_q;
  logic       mod_s2_q;
  logic       ack_q;
  logic [31:0] rdata_q;
  logic [1:0]  resp_q;
  adcr_pkg::adcr_drive_type drive_d;
  adcr_pkg::adcr_drive_type drive_q;

  // Bus decode: one wait state, answer on second edge
  wire        req      = (avs_read | avs_write) & ~ack_q;
  wire        wr_ok    = avs_write & ack_q & avs_byteenable[0];
  wire        hit_n_on = avs_address == adcr_pkg::N_ON_IDX;
  wire        hit_p_cw = avs_address == adcr_pkg::P_CW_IDX;
  wire        hit_p_md = avs_address == adcr_pkg::P_MOD_IDX;
  wire        hit_noff = avs_address == adcr_pkg::N_OFF_IDX;
  wire        hit_ctrl = avs_address == adcr_pkg::CTRL_IDX;
  wire        hit_stat = avs_address == adcr_pkg::STAT_IDX;
  wire        hit_any  = hit_n_on | hit_p_cw | hit_p_md | hit_noff | hit_ctrl | hit_stat;
  wire [7:0]  wbyte    = avs_writedata[7:0];

  // Control fields
  wire power_down  = ctrl_q[adcr_pkg::CTRL_PD];
  wire full_ask    = ctrl_q[adcr_pkg::CTRL_ASK];
  wire drivers_on  = ctrl_q[adcr_pkg::CTRL_TX1] | ctrl_q[adcr_pkg::CTRL_TX2];
  wire modulating  = mod_s2_q | ctrl_q[adcr_pkg::CTRL_MOD];

  // N field choice
  wire [7:0] n_src    = drivers_on ? n_on_q : n_off_q; // [R3] [R10]
  wire [3:0] n_cw     = n_src[adcr_pkg::N_CW_LSB +: adcr_pkg::N_W];
  wire [3:0] n_md     = n_src[adcr_pkg::N_W-1:0];
  wire [3:0] n_raw    = modulating ? n_md : n_cw; // [R2]

  // P field choice; full ASK drives zero P conductance while modulating
  wire [5:0] p_cw     = p_cw_q[adcr_pkg::P_W-1:0];
  wire [5:0] p_md     = full_ask ? 6'h00 : p_mod_q[adcr_pkg::P_W-1:0]; // [R8]
  wire [5:0] p_raw    = modulating ? p_md : p_cw; // [R2]
  wire       p_md_sel = modulating & ~full_ask;

  wire [3:0] n_eff    = power_down ? (n_raw | 4'h8) : n_raw; // [R5]
  wire [5:0] p_eff    = (power_down & (~modulating | p_md_sel)) ? (p_raw | 6'h20) : p_raw; // [R5]

  wire [7:0] stat_val = {2'h0, drivers_on, modulating, n_eff};

  always_comb begin
    drive_d.n_cond   = n_eff;
    drive_d.p_cond   = p_eff;
    drive_d.full_ask = full_ask & modulating;
  end

  wire [7:0] rd_byte = hit_n_on ? n_on_q :
                       hit_p_cw ? (p_cw_q & adcr_pkg::P_MASK) : // [R9]
                       hit_p_md ? (p_mod_q & adcr_pkg::P_MASK) : // [R9]
                       hit_noff ? n_off_q :
                       hit_ctrl ? ctrl_q :
                       hit_stat ? stat_val : 8'h00;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      n_on_q  <= adcr_pkg::N_ON_RST; // [R1]
      p_cw_q  <= adcr_pkg::P_CW_RST; // [R6]
      p_mod_q <= adcr_pkg::P_MOD_RST; // [R7]
      n_off_q <= adcr_pkg::N_OFF_RST;
      ctrl_q  <= adcr_pkg::CTRL_RST;
    end else if (wr_ok) begin
      if (hit_n_on) n_on_q <= wbyte; // [R1]
      if (hit_p_cw) p_cw_q <= wbyte & adcr_pkg::P_MASK; // [R6] [R11]
      if (hit_p_md) p_mod_q <= wbyte & adcr_pkg::P_MASK; // [R7] [R11]
      if (hit_noff) n_off_q <= wbyte; // [R10]
      if (hit_ctrl) ctrl_q <= wbyte & adcr_pkg::CTRL_MASK;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
      resp_q  <= 2'h0;
    end else begin
      ack_q   <= req;
      rdata_q <= (req & avs_read) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      resp_q  <= (req & ~hit_any) ? 2'h2 : 2'h0;
    end
  end

  // Modulation input comes from the transmitter pin domain
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      mod_s1_q <= 1'b0;
      mod_s2_q <= 1'b0;
      drive_q  <= '0;
    end else begin
      mod_s1_q <= modulation_in;
      mod_s2_q <= mod_s1_q;
      drive_q  <= drive_d;
    end
  end

  assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
  assign avs_readdata    = rdata_q;
  assign avs_response    = resp_q;
  assign n_conductance   = drive_q.n_cond;
  assign p_conductance   = drive_q.p_cond;
  assign forced_full_ask = drive_q.full_ask;

  adcr_weight #(.W(4)) u_n_weight (
    .field      (drive_q.n_cond),
    .power_down (1'b0),
    .segments   (n_segments)
  ); // [R4]

  adcr_weight #(.W(6)) u_p_weight (
    .field      (drive_q.p_cond),
    .power_down (1'b0),
    .segments   (p_segments)
  ); // [R4]

endmodule // adcr_regs

//--- bench/adcr_regs_checker.sv
// Checker of bus timing and drive outputs
`timescale 1ns/10ps
module adcr_regs_checker (
  input wire logic        mclk,
  input wire logic        sys_rst,
  input wire logic [7:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic [1:0]  avs_response,
  input wire logic [3:0]  n_conductance,
  input wire logic [5:0]  p_conductance,
  input wire logic        forced_full_ask,
  input wire logic [14:0] n_segments,
  input wire logic [62:0] p_segments
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  wire req  = avs_read || avs_write;
  wire done = req && !avs_waitrequest;
  wire map  = avs_address >= adcr_pkg::N_ON_IDX && avs_address <= adcr_pkg::STAT_IDX;
  wire resv = avs_address == adcr_pkg::P_CW_IDX || avs_address == adcr_pkg::P_MOD_IDX;
  a_one_wait: assert property (req && avs_waitrequest |=> !avs_waitrequest) else $error("no answer");
  a_idle_free: assert property (!req |-> !avs_waitrequest) else $error("wait while idle");
  a_upper_zero: assert property (done && avs_read |-> avs_readdata[31:8] == 24'h0) else $error("upper bits");
  a_resv_zero: assert property (done && avs_read && resv |-> avs_readdata[7:6] == 2'h0) else $error("resv");
  a_bad_addr: assert property (done && !map |-> avs_response == 2'h2) else $error("unmapped response");
  a_good_addr: assert property (done && map |-> avs_response == 2'h0) else $error("mapped response");
  a_n_weight: assert property (
    n_segments == {{8{n_conductance[3]}}, {4{n_conductance[2]}},
    {2{n_conductance[1]}}, n_conductance[0]}) else $error("n weight");
  a_p_weight: assert property (
    p_segments == {{32{p_conductance[5]}}, {16{p_conductance[4]}},
    {8{p_conductance[3]}}, {4{p_conductance[2]}}, {2{p_conductance[1]}}, p_conductance[0]})
    else $error("p weight");
  a_ask_void: assert property (forced_full_ask |-> p_conductance == 6'h00) else $error("ask p");
endmodule // adcr_regs_checker
bind adcr_regs adcr_regs_checker u_adcr_regs_checker (.*);

//--- bench/adcr_regs_bench.sv
// Self-checking bench of the conductance bank
`timescale 1ns/10ps
module adcr_regs_bench;
  logic        mclk, sys_rst, avs_read, avs_write, modulation_in, forced_full_ask, avs_waitrequest;
  logic [7:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, r;
  logic [1:0]  avs_response;
  logic [3:0]  n_conductance, avs_byteenable;
  logic [5:0]  p_conductance;
  logic [14:0] n_segments;
  logic [62:0] p_segments;
  int          bad_count = 0;
  int          n_tests = 0;
  logic [7:0]  rows [6][4] = '{'{8'h27, 8'h88, 8'h5a, 8'h5a}, '{8'h28, 8'h20, 8'hce, 8'h0e},
    '{8'h29, 8'h20, 8'hc1, 8'h01}, '{8'h2a, 8'h88, 8'h37, 8'h37}, '{8'h2d, 8'h0, 8'h55, 8'h0},
    '{8'h26, 8'h0, 8'h11, 8'h0}};
  adcr_regs u_adcr_regs (
    .mclk            (mclk),
    .sys_rst         (sys_rst),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_writedata   (avs_writedata),
    .avs_byteenable  (avs_byteenable),
    .avs_readdata    (avs_readdata),
    .avs_waitrequest (avs_waitrequest),
    .avs_response    (avs_response),
    .modulation_in   (modulation_in),
    .n_conductance   (n_conductance),
    .p_conductance   (p_conductance),
    .forced_full_ask (forced_full_ask),
    .n_segments      (n_segments),
    .p_segments      (p_segments)
  );
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_tests++;
    if (s !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_read <= !w;
    avs_write <= w;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0)
      @(posedge mclk);
    r = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic drive(input logic [7:0] c, input logic m, input logic [3:0] n, input logic [5:0] p,
    input logic a);
    bus(1'b1, adcr_pkg::CTRL_IDX, c);
    modulation_in <= m;
    repeat (5) @(posedge mclk);
    chk("n_conductance", {28'h0, n}, {28'h0, n_conductance});
    chk("p_conductance", {26'h0, p}, {26'h0, p_conductance});
    chk("forced_full_ask", {31'h0, a}, {31'h0, forced_full_ask});
    $display("test drive %h done", c);
  endtask
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    #20000;
    bad_count++;
    print_verdict();
  end
  initial begin
    sys_rst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 8'h0;
    avs_writedata = 32'h0;
    modulation_in = 1'b0;
    avs_byteenable = 4'h1;
    repeat (5) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    foreach (rows[i]) begin
      bus(1'b0, rows[i][0], 8'h0);
      chk("reset", {24'h0, rows[i][1]}, r);
      bus(1'b1, rows[i][0], rows[i][2]);
      bus(1'b0, rows[i][0], 8'h0);
      chk("readback", {24'h0, rows[i][3]}, r);
    end
    $display("test rows done");
    drive(8'h04, 1'b0, 4'h5, 6'h0e, 1'b0);
    drive(8'h08, 1'b1, 4'ha, 6'h01, 1'b0);
    drive(8'h00, 1'b1, 4'h7, 6'h01, 1'b0);
    drive(8'h01, 1'b0, 4'hb, 6'h2e, 1'b0);
    drive(8'h06, 1'b1, 4'ha, 6'h00, 1'b1);
    drive(8'h11, 1'b0, 4'hf, 6'h21, 1'b0);
    bus(1'b0, adcr_pkg::STAT_IDX, 8'h0);
    chk("status", 32'h0000_001f, r);
    $display("test status done");
    drive(8'h06, 1'b0, 4'h5, 6'h0e, 1'b0);
    avs_byteenable <= 4'h0;
    bus(1'b1, adcr_pkg::N_ON_IDX, 8'h33);
    avs_byteenable <= 4'h1;
    bus(1'b0, adcr_pkg::N_ON_IDX, 8'h0);
    chk("byteenable", 32'h0000_005a, r);
    $display("test byteenable done");
    modulation_in <= 1'b0;
    sys_rst <= 1'b1;
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge mclk);
    chk("n_conductance", 32'h0000_0008, {28'h0, n_conductance});
    chk("p_conductance", 32'h0000_0020, {26'h0, p_conductance});
    chk("n_segments", 32'h0000_7f80, {17'h0, n_segments});
    bus(1'b0, adcr_pkg::N_ON_IDX, 8'h0);
    chk("reset again", 32'h0000_0088, r);
    $display("test mid reset done");
    print_verdict();
  end
endmodule // adcr_regs_bench
